// File: clock_mask_pkg.sv
// Constants, register map and types for the secondary clock mask and speed select block.
// Assumes a single 20 MHz APB clock and an active-low asynchronous primary reset.
package clock_mask_pkg;

    // ======================================================================
    // Clocking and timing
    // ======================================================================
    localparam int CLOCK_PERIOD_NS = 50;
    localparam int SHIFT_HALF_NS = 100;
    // Least time, so round up to whole cycles, never below one
    localparam int SHIFT_HALF_RAW = (SHIFT_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int SHIFT_HALF_CYCLES = (SHIFT_HALF_RAW < 1) ? 1 : SHIFT_HALF_RAW;
    localparam int TIMER_WIDTH = 4;

    // ======================================================================
    // Secondary clock outputs and serial mask pins
    // ======================================================================
    localparam int CLOCK_OUTPUTS = 10;
    localparam int COUNT_WIDTH = 4;
    localparam int GPIO_WIDTH = 4;
    localparam int GPIO_SHIFT_CLOCK = 0;
    localparam int GPIO_SHIFT_LOAD = 2;
    localparam int SYNC_WIDTH = 4;

    // ======================================================================
    // Register map (byte addresses)
    // ======================================================================
    localparam int ADDR_WIDTH = 8;
    localparam logic [7:0] CONTROL_OFFSET = 8'h00;
    localparam logic [7:0] CLOCK_DISABLE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam int CONTROL_SEC_RESET_BIT = 0;
    localparam logic CONTROL_RESET_VALUE = 1'b0;
    localparam logic [9:0] CLOCK_DISABLE_RESET_VALUE = 10'h000;
    localparam int STATUS_MASK_DONE_BIT = 0;
    localparam int STATUS_FAST_CAPABLE_BIT = 1;
    localparam int STATUS_PRIMARY_FAST_BIT = 2;
    localparam int STATUS_SECONDARY_SENSE_BIT = 3;
    localparam int STATUS_SECONDARY_FAST_BIT = 4;

    // ======================================================================
    // Types
    // ======================================================================
    typedef enum logic [1:0] {
        SHIFT_LOAD,
        SHIFT_LOW,
        SHIFT_HIGH,
        SHIFT_DONE
    } shift_state_type;

    typedef struct packed {
        logic mask_bit;
        logic fast_capable;
        logic primary_fast;
        logic secondary_sense;
    } strap_type;

endpackage

// File: level_sync.sv
// Two-flop synchroniser for a group of slow level inputs.
// Assumes each bit is a quasi-static level; bits are not coherent with each other.
`timescale 1ns/1ps
module level_sync #(
    parameter int WIDTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] first_stage;

    // ======================================================================
    // Synchroniser chain; first stage feeds only the second
    // ======================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_stage <= '0;
            sync_out <= '0;
        end else begin
            first_stage <= async_in;
            sync_out <= first_stage;
        end
    end

endmodule

// File: secondary_clock_control.sv
// Secondary clock mask loader, secondary reset hold and bus speed select, with APB registers.
// Assumes strap and pin inputs are asynchronous and presetn is the primary bus reset.
//
// Functional notes
// - Start mask shifting once primary reset releases while secondary reset is held.
// - Each received mask bit lands in the clock disable register, gating one output.
// - Mask input held low leaves all secondary clocks enabled.
// - Mask input held high parks every secondary clock at static high.
// - Capability strap high allows 66 MHz; low restricts to 33 MHz.
// - Primary speed input low: drive secondary speed pin low for 33 MHz.
// - Primary speed input and capability strap both high: release open-drain secondary speed pin, only sense it.
// - Secondary reset held until primary reset gone, mask loaded, control bit clear.
// - Mask loads over gpio pins and mask input; software may write disable bits.
//
// Added by the designer: the address map and the APB register port.
`timescale 1ns/1ps
module secondary_clock_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_mask_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic mask_in,
    input wire logic fast_capable_strap,
    input wire logic primary_fast_enable,
    input wire logic secondary_fast_enable_in,
    output logic secondary_fast_enable_out,
    output logic secondary_fast_enable_oe,
    input wire logic [clock_mask_pkg::GPIO_WIDTH-1:0] gpio_in,
    output logic [clock_mask_pkg::GPIO_WIDTH-1:0] gpio_out,
    output logic [clock_mask_pkg::GPIO_WIDTH-1:0] gpio_oe,
    output logic [clock_mask_pkg::CLOCK_OUTPUTS-1:0] clock_out_disable,
    output logic secondary_reset_n
);
    import clock_mask_pkg::*;

    // ======================================================================
    // Declarations
    // ======================================================================
    strap_type straps;
    shift_state_type state;
    shift_state_type next_state;
    logic [TIMER_WIDTH-1:0] timer;
    logic [COUNT_WIDTH-1:0] bit_count;
    logic [CLOCK_OUTPUTS-1:0] clock_disable;
    logic sec_reset_bit;
    logic [GPIO_WIDTH-1:0] next_gpio_out;
    logic [GPIO_WIDTH-1:0] next_gpio_oe;

    // Register offset match, shared by read and write decode
    function automatic logic hits(input logic [ADDR_WIDTH-1:0] addr,
                                  input logic [7:0] offset);
        hits = (addr == offset);
    endfunction

    // ======================================================================
    // Pin synchronisers
    // ======================================================================
    level_sync #(
        .WIDTH(SYNC_WIDTH)
    ) pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({mask_in, fast_capable_strap, primary_fast_enable, secondary_fast_enable_in}),
        .sync_out(straps)
    );

    // ======================================================================
    // Serial mask shift sequencer
    // ======================================================================
    // Half-period timer paces the gpio shift clock
    wire timer_done = (timer == TIMER_WIDTH'(SHIFT_HALF_CYCLES - 1));
    wire last_bit = (bit_count == COUNT_WIDTH'(CLOCK_OUTPUTS - 1));
    wire sample_bit = (state == SHIFT_LOW) && timer_done;
    wire shifting = (state != SHIFT_DONE);

    // Reset leaves the sequencer in LOAD, so shifting starts at release
    always_comb begin
        next_state = state;
        case (state)
            SHIFT_LOAD: begin
                if (timer_done) begin
                    next_state = SHIFT_LOW;
                end
            end
            SHIFT_LOW: begin
                if (timer_done) begin
                    next_state = SHIFT_HIGH;
                end
            end
            SHIFT_HIGH: begin
                if (timer_done) begin
                    next_state = last_bit ? SHIFT_DONE : SHIFT_LOW;
                end
            end
            SHIFT_DONE: begin
                next_state = SHIFT_DONE;
            end
            default: begin
                next_state = SHIFT_DONE;
            end
        endcase
    end

    // Load strobe low in LOAD, shift clock high in HIGH; pins released after
    always_comb begin
        next_gpio_out = '0;
        next_gpio_oe = '0;
        if (next_state != SHIFT_DONE) begin
            next_gpio_oe[GPIO_SHIFT_CLOCK] = 1'b1;
            next_gpio_oe[GPIO_SHIFT_LOAD] = 1'b1;
            next_gpio_out[GPIO_SHIFT_LOAD] = (next_state != SHIFT_LOAD);
            next_gpio_out[GPIO_SHIFT_CLOCK] = (next_state == SHIFT_HIGH);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SHIFT_LOAD;
            timer <= '0;
            bit_count <= '0;
            gpio_out <= '0;
            gpio_oe <= '0;
        end else begin
            state <= next_state;
            timer <= (timer_done || !shifting) ? '0 : timer + 1'b1;
            gpio_out <= next_gpio_out;
            gpio_oe <= next_gpio_oe;
            if (state == SHIFT_HIGH && timer_done) begin
                bit_count <= bit_count + 1'b1;
            end
        end
    end

    // ======================================================================
    // APB slave: zero wait state, error on unmapped address
    // ======================================================================
    wire setup = psel && !penable;
    wire access = psel && penable && pready;
    wire hit_control = hits(paddr, CONTROL_OFFSET);
    wire hit_disable = hits(paddr, CLOCK_DISABLE_OFFSET);
    wire hit_status = hits(paddr, STATUS_OFFSET);
    wire mapped = hit_control || hit_disable || hit_status;
    wire write_control = access && pwrite && hit_control;
    wire write_disable = access && pwrite && hit_disable;
    wire secondary_fast = straps.fast_capable && straps.primary_fast && straps.secondary_sense;

    wire [31:0] status_word = 32'(
        {secondary_fast, straps.secondary_sense, straps.primary_fast,
         straps.fast_capable, !shifting});
    wire [31:0] read_word = hit_control ? 32'(sec_reset_bit) :
                            hit_disable ? 32'(clock_disable) :
                            hit_status ? status_word : 32'h0000_0000;

    // Read data and ready are captured in setup, so they come from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !mapped;
            prdata <= (setup && !pwrite) ? read_word : 32'h0000_0000;
        end
    end

    // ======================================================================
    // Control and clock disable registers
    // ======================================================================
    // A mask sample beats a software write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sec_reset_bit <= CONTROL_RESET_VALUE;
            clock_disable <= CLOCK_DISABLE_RESET_VALUE;
        end else begin
            if (write_control) begin
                sec_reset_bit <= pwdata[CONTROL_SEC_RESET_BIT];
            end
            if (sample_bit) begin
                clock_disable[bit_count] <= straps.mask_bit;
            end else if (write_disable) begin
                clock_disable <= pwdata[CLOCK_OUTPUTS-1:0];
            end
        end
    end

    // ======================================================================
    // Pin outputs
    // ======================================================================
    // Open drain: the pin only ever pulls low, so its data flop stays low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_out_disable <= '0;
            secondary_reset_n <= 1'b0;
            secondary_fast_enable_oe <= 1'b1;
            secondary_fast_enable_out <= 1'b0;
        end else begin
            secondary_fast_enable_out <= 1'b0;
            // Disabled outputs park high; all-zero mask keeps all running
            clock_out_disable <= clock_disable;
            secondary_reset_n <= !shifting && !sec_reset_bit;
            // Pull low unless both strap and primary allow the fast rate
            secondary_fast_enable_oe <= !(straps.fast_capable && straps.primary_fast);
        end
    end

endmodule

// File: clock_mask_monitor.sv
// Port checker for the secondary clock mask and speed select block.
// Assumes the single pclk domain with presetn as its reset; bound below.
`timescale 1ns/1ps
module clock_mask_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [clock_mask_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic fast_capable_strap,
    input wire logic primary_fast_enable,
    input wire logic secondary_fast_enable_oe,
    input wire logic [clock_mask_pkg::GPIO_WIDTH-1:0] gpio_out,
    input wire logic [clock_mask_pkg::GPIO_WIDTH-1:0] gpio_oe,
    input wire logic [clock_mask_pkg::CLOCK_OUTPUTS-1:0] clock_out_disable,
    input wire logic secondary_reset_n
);
    import clock_mask_pkg::*;
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ==========================================================
    // Sequences of the serial mask load
    // ==========================================================
    sequence load_low;
        gpio_oe[GPIO_SHIFT_LOAD] && !gpio_out[GPIO_SHIFT_LOAD];
    endsequence
    sequence low_phase;
        !gpio_out[GPIO_SHIFT_CLOCK] [*2] ##1 gpio_out[GPIO_SHIFT_CLOCK];
    endsequence
    // Load strobe must follow each release of primary reset
    a_mask_start: assert property ($rose(presetn) |-> ##[0:2] load_low)
        else $error("mask load did not start");
    // Each shift clock low phase lasts two cycles then rises
    a_shift_phase: assert property (gpio_oe[GPIO_SHIFT_CLOCK] && $fell(gpio_out[GPIO_SHIFT_CLOCK])
        |-> low_phase)
        else $error("shift clock phase wrong");
    a_release_after: assert property ($rose(secondary_reset_n) |-> $past(gpio_oe) == 4'h0)
        else $error("secondary reset released while shifting");
    // Speed pin: three cycle sync latency, so four stable samples suffice
    a_oe_slow: assert property (!primary_fast_enable [*4] |-> secondary_fast_enable_oe)
        else $error("secondary speed pin not pulled low");
    // Release edge excluded: the synchronisers still hold reset values there
    a_oe_fast: assert property ((presetn && fast_capable_strap && primary_fast_enable) [*4]
        |-> !secondary_fast_enable_oe)
        else $error("secondary speed pin not released");
    a_cap_low: assert property (!fast_capable_strap [*4] |-> secondary_fast_enable_oe)
        else $error("slow strap ignored");
    a_write_disable: assert property (psel && penable && pready && pwrite
        && paddr == CLOCK_DISABLE_OFFSET
        |-> ##2 clock_out_disable == $past(pwdata[CLOCK_OUTPUTS-1:0], 2))
        else $error("clock disable write not applied");
    a_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not a single access cycle");
    a_err_ready: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("pslverr without pready or with data");
endmodule
bind secondary_clock_control clock_mask_monitor u_clock_mask_monitor (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fast_capable_strap(fast_capable_strap), .primary_fast_enable(primary_fast_enable),
    .secondary_fast_enable_oe(secondary_fast_enable_oe), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .clock_out_disable(clock_out_disable),
    .secondary_reset_n(secondary_reset_n));

// File: board_model.sv
// Board side model: straps, serial mask source and the open-drain speed pin.
// Assumes the mask source advances one bit per rising shift clock.
`timescale 1ns/1ps
module board_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [9:0] pattern,
    input wire logic cap,
    input wire logic pf,
    input wire logic pull,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic sec_out,
    input wire logic sec_oe,
    output logic mask_in,
    output logic fast_capable_strap,
    output logic primary_fast_enable,
    output logic sec_in
);
    logic [3:0] idx;
    logic last_clk;
    // Bit index steps on each rising shift clock, lowest output first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx <= 4'h0;
            last_clk <= 1'b0;
        end else begin
            last_clk <= gpio_out[0];
            if (gpio_oe[0] && gpio_out[0] && !last_clk) begin
                idx <= idx + 4'h1;
            end
        end
    end
    // Straps are static levels; the speed pin resolves wired-and with the pull
    assign mask_in = (idx < 4'hA) ? pattern[idx] : pattern[9];
    assign fast_capable_strap = cap;
    assign primary_fast_enable = pf;
    assign sec_in = sec_oe ? sec_out : pull;
endmodule

// File: tb_top.sv
// Self-checking bench for the secondary clock mask and speed select block.
// Assumes the board model supplies straps and the serial mask.
`timescale 1ns/1ps
module tb_top;
    import clock_mask_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [9:0] pattern = 10'h000;
    logic cap = 1'b1;
    logic pf = 1'b1;
    logic pull = 1'b1;
    logic [31:0] prdata, rd;
    logic pready, pslverr, mask_in, fsc, pfe, sec_in, sec_out, sec_oe, srn, err;
    logic [3:0] gpio_out, gpio_oe;
    logic [9:0] cod;
    int miscompares = 0;
    int n_checks = 0;
    // ==========================================================
    // Clock, design, board and watchdog
    // ==========================================================
    initial begin
        forever #25 pclk = ~pclk;
    end
    secondary_clock_control u_secondary_clock_control (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mask_in(mask_in),
        .fast_capable_strap(fsc), .primary_fast_enable(pfe),
        .secondary_fast_enable_in(sec_in), .secondary_fast_enable_out(sec_out),
        .secondary_fast_enable_oe(sec_oe), .gpio_in(4'h0), .gpio_out(gpio_out),
        .gpio_oe(gpio_oe), .clock_out_disable(cod), .secondary_reset_n(srn));
    board_model u_board_model (.pclk(pclk), .presetn(presetn), .pattern(pattern), .cap(cap),
        .pf(pf), .pull(pull), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .sec_out(sec_out),
        .sec_oe(sec_oe), .mask_in(mask_in), .fast_capable_strap(fsc),
        .primary_fast_enable(pfe), .sec_in(sec_in));
    // Whole run is well under 3000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        results();
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // One APB transfer; waits for pready, only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Reset with a given mask, check the hold, then wait for the release
    task automatic start(input logic [9:0] pat);
        int n;
        pattern <= pat;
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check({sec_oe, srn}, 32'h2);
        presetn <= 1'b1;
        repeat (12) @(posedge pclk);
        check(srn, 32'h0);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (srn !== 1'b1 && n < 100);
        @(posedge pclk);
        check(srn, 32'h1);
    endtask
    // ==========================================================
    // Scenarios
    // ==========================================================
    task automatic t_mask();
        logic [9:0] pats [4] = '{10'h000, 10'h3FF, 10'h2A5, 10'h15A};
        foreach (pats[i]) begin
            start(pats[i]);
            check(cod, pats[i]);
            apb(1'b0, STATUS_OFFSET, 32'h0);
            check(rd[0], 32'h1);
        end
    endtask
    task automatic t_regs();
        apb(1'b0, CONTROL_OFFSET, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, CONTROL_OFFSET, 32'h1);
        @(posedge pclk);
        check(srn, 32'h0);
        apb(1'b1, CONTROL_OFFSET, 32'h0);
        @(posedge pclk);
        check(srn, 32'h1);
        apb(1'b1, CLOCK_DISABLE_OFFSET, 32'h3C3);
        apb(1'b0, CLOCK_DISABLE_OFFSET, 32'h0);
        check(rd, 32'h3C3);
        check(cod, 32'h3C3);
        apb(1'b1, 8'h0C, 32'hFF);
        check(err, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, STATUS_OFFSET, 32'h0);
        check(err, 32'h0);
    endtask
    task automatic t_speed();
        logic [2:0] s;
        logic pin;
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            cap <= s[2];
            pf <= s[1];
            pull <= s[0];
            repeat (6) @(posedge pclk);
            pin = (s[2] & s[1]) ? s[0] : 1'b0;
            check(sec_oe, !(s[2] & s[1]));
            apb(1'b0, STATUS_OFFSET, 32'h0);
            check(rd[4:1], {s[2] & s[1] & pin, pin, s[1], s[2]});
        end
    endtask
    initial begin
        t_mask();
        t_regs();
        t_speed();
        results();
    end
endmodule
